/* core/dss_drive_stop_sequencer.sv */
// Drive stop sequencer with classic Wishbone register slave
// Function
// - Ramping flag high only while output changes
// - Stop mode field picks ramp, coast, DC brake, stop-ramp
// - Ramp mode uses decel time when nonzero
// - Coast mode removes drive, motor freewheels
// - DC brake stop applies low frequency current
// - DC brake under vector control coasts instead
// - Stop-ramp mode ramps down over stop time
// - Zero speed threshold in 0.1 percent of maximum
// - Threshold never below 0.5 Hz floor
// - Hold zero speed for delay before quench
// - Low fast-stop request uses fast torque limit
// - Fast stop timeout quenches unfinished stop
// - Trims removed at settable Hz/s rate
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module dss_drive_stop_sequencer #(
  parameter logic [15:0]     FULL_SCALE = dss_pkg::FULL_SPEED,
  parameter int unsigned     MAX_DHZ    = dss_pkg::MAX_FREQ_DHZ,
  parameter int unsigned     CYC_TENTH  = dss_pkg::CYC_PER_TENTH,
  parameter longint unsigned CLOCK_HZ   = dss_pkg::CLK_HZ
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               wbCyc,
  input  wire logic               wbStb,
  input  wire logic               wbWe,
  input  wire logic [7:0]         wbAdr,
  input  wire logic [3:0]         wbSel,
  input  wire logic [31:0]        wbDatW,
  output logic      [31:0]        wbDatR,
  output logic                    wbAck,
  input  wire logic               runCmd,
  input  wire logic               fastStopN,
  input  wire logic               vectorMode,
  input  wire logic [15:0]        refSpeed,
  input  wire logic signed [15:0] trimIn,
  output logic signed [17:0]      speedDemand,
  output logic                    driveEnable,
  output logic                    dcBrake,
  output logic      [15:0]        torqueLimit,
  output logic                    quenched,
  output logic                    rampingActive
);
  import dss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    logic [1:0]         mode;
    logic [15:0]        decelTime;
    logic [15:0]        stopTime;
    logic [15:0]        zeroPct;
    logic [15:0]        stopDelay;
    logic [15:0]        fastLimit;
    logic [15:0]        fastTime;
    logic [15:0]        trimRate;
    logic [15:0]        fastTlim;
    logic [15:0]        normTlim;
    dss_state_type      state;
    logic [15:0]        speed;
    logic signed [15:0] trimLive;
    logic [47:0]        rampAcc;
    logic [47:0]        trimAcc;
    logic [47:0]        timer;
    logic [47:0]        fastTimer;
    logic               rampActive;
    logic               atZero;
    logic signed [17:0] demand;
    logic               drive;
    logic               brake;
    logic               idle;
    logic [15:0]        tlim;
    logic               ack;
    logic [31:0]        rdat;
  } dss_regs_type;

  dss_regs_type r;
  dss_regs_type next_r;

  // Merge a write into a 16-bit setting by byte lane
  function automatic logic [15:0] wrHalf(input logic [15:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction : wrHalf

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic        busHit;
    logic [31:0] rdMux;
    logic [47:0] spdScaled;
    logic [47:0] pctLimit;
    logic [47:0] floorScaled;
    logic [47:0] floorLimit;
    logic        zeroNow;
    logic [15:0] rampTime;
    logic [47:0] rampPeriod;
    logic [47:0] rampSum;
    logic [47:0] rampStep;
    logic [47:0] trimStep;
    logic [47:0] trimPeriod;
    logic [47:0] trimSum;
    busHit      = wbCyc & wbStb & ~r.ack;
    rdMux       = 32'h0000_0000;
    spdScaled   = 48'(r.speed) * 48'(PCT_SCALE);
    pctLimit    = 48'(r.zeroPct) * 48'(FULL_SCALE);
    floorScaled = 48'(r.speed) * 48'(MAX_DHZ);
    floorLimit  = 48'(FLOOR_DHZ) * 48'(FULL_SCALE);
    zeroNow     = (spdScaled <= pctLimit) | (floorScaled <= floorLimit);
    rampTime    = r.decelTime;
    rampPeriod  = 48'h0;
    rampSum     = r.rampAcc + 48'(FULL_SCALE);
    rampStep    = 48'h0;
    trimStep    = 48'(r.trimRate) * 48'(FULL_SCALE) * 48'(HZ_TO_DHZ);
    trimPeriod  = 48'(MAX_DHZ) * 48'(CLOCK_HZ);
    trimSum     = r.trimAcc + trimStep;
    next_r      = r;
    next_r.ack  = 1'b0;

    // Register read mux
    case (wbAdr)
      ADDR_CTRL:       rdMux = {30'h0, r.mode};
      ADDR_DECEL_TIME: rdMux = {16'h0, r.decelTime};
      ADDR_STOP_TIME:  rdMux = {16'h0, r.stopTime};
      ADDR_ZERO_PCT:   rdMux = {16'h0, r.zeroPct};
      ADDR_STOP_DELAY: rdMux = {16'h0, r.stopDelay};
      ADDR_FAST_LIMIT: rdMux = {16'h0, r.fastLimit};
      ADDR_FAST_TIME:  rdMux = {16'h0, r.fastTime};
      ADDR_TRIM_RATE:  rdMux = {16'h0, r.trimRate};
      ADDR_FAST_TLIM:  rdMux = {16'h0, r.fastTlim};
      ADDR_NORM_TLIM:  rdMux = {16'h0, r.normTlim};
      ADDR_STATUS: begin
        rdMux[STAT_RAMPING]      = r.rampActive;
        rdMux[STAT_ZERO]         = r.atZero;
        rdMux[STAT_STATE +: 6]   = r.state;
      end
      ADDR_DEMAND:     rdMux = 32'(r.demand);
      default:         rdMux = 32'h0000_0000;
    endcase

    // Bus slave, one wait state, unmapped reads zero
    if (busHit) begin
      next_r.ack = 1'b1;
      if (wbWe) begin
        case (wbAdr)
          ADDR_CTRL: begin
            if (wbSel[0]) begin
              next_r.mode = wbDatW[1:0];
            end
          end
          ADDR_DECEL_TIME: next_r.decelTime = wrHalf(r.decelTime, wbDatW, wbSel);
          ADDR_STOP_TIME:  next_r.stopTime  = wrHalf(r.stopTime, wbDatW, wbSel);
          ADDR_ZERO_PCT:   next_r.zeroPct   = wrHalf(r.zeroPct, wbDatW, wbSel);
          ADDR_STOP_DELAY: next_r.stopDelay = wrHalf(r.stopDelay, wbDatW, wbSel);
          ADDR_FAST_LIMIT: next_r.fastLimit = wrHalf(r.fastLimit, wbDatW, wbSel);
          ADDR_FAST_TIME:  next_r.fastTime  = wrHalf(r.fastTime, wbDatW, wbSel);
          ADDR_TRIM_RATE:  next_r.trimRate  = wrHalf(r.trimRate, wbDatW, wbSel);
          ADDR_FAST_TLIM:  next_r.fastTlim  = wrHalf(r.fastTlim, wbDatW, wbSel);
          ADDR_NORM_TLIM:  next_r.normTlim  = wrHalf(r.normTlim, wbDatW, wbSel);
          default: ;
        endcase
      end else begin
        next_r.rdat = rdMux;
      end
    end

    // Ramp period in clocks from the active stop time
    if (r.state == ST_FAST) begin
      rampTime = r.fastTime;
    end else if (r.mode == MODE_STOP_RAMP) begin
      rampTime = r.stopTime;
    end
    rampPeriod = 48'(rampTime) * 48'(CYC_TENTH);

    // Sequencer
    case (r.state)
      ST_IDLE: begin
        next_r.speed = 16'h0000;
        if (runCmd && fastStopN) begin
          next_r.state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_r.speed    = refSpeed;
        next_r.trimLive = trimIn;
        next_r.rampAcc  = 48'h0;
        next_r.trimAcc  = 48'h0;
        next_r.timer    = 48'h0;
        if (!fastStopN) begin
          next_r.state     = ST_FAST;
          next_r.fastTimer = 48'h0;
        end else if (!runCmd) begin
          case (r.mode)
            MODE_RAMP: begin
              next_r.state = (r.decelTime == 16'h0000) ? ST_IDLE : ST_RAMP;
            end
            MODE_COAST: next_r.state = ST_IDLE;
            MODE_DC_BRAKE: begin
              next_r.state = vectorMode ? ST_IDLE : ST_DCB;
            end
            MODE_STOP_RAMP: next_r.state = ST_RAMP;
            default: next_r.state = ST_IDLE;
          endcase
        end
      end
      ST_RAMP, ST_FAST: begin
        if (r.state == ST_FAST) begin
          next_r.fastTimer = r.fastTimer + 48'h1;
        end
        if (rampPeriod == 48'h0) begin
          next_r.speed = 16'h0000;
        end else if (rampSum >= rampPeriod) begin
          rampStep       = rampSum / rampPeriod;  // Short times drop several LSBs a clock
          next_r.rampAcc = rampSum % rampPeriod;
          next_r.speed   = (48'(r.speed) <= rampStep) ? 16'h0000 : r.speed - 16'(rampStep);
        end else begin
          next_r.rampAcc = rampSum;
        end
        if (r.state == ST_RAMP && !fastStopN) begin
          next_r.state     = ST_FAST;
          next_r.fastTimer = 48'h0;
        end else if (r.state == ST_FAST &&
                     r.fastTimer >= 48'(r.fastLimit) * 48'(CYC_TENTH)) begin
          next_r.state = ST_IDLE;
        end else if (zeroNow) begin
          next_r.state = ST_HOLD;
          next_r.speed = 16'h0000;
          next_r.timer = 48'h0;
        end
      end
      ST_HOLD, ST_DCB: begin
        next_r.speed = 16'h0000;
        next_r.timer = r.timer + 48'h1;
        if (r.timer >= 48'(r.stopDelay) * 48'(CYC_TENTH)) begin
          next_r.state = ST_IDLE;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase

    // Trim removal while stopping, one step toward zero per period
    if (r.state != ST_RUN) begin
      if (r.trimLive == 16'sh0000) begin
        next_r.trimAcc = 48'h0;
      end else if (trimSum >= trimPeriod) begin
        next_r.trimAcc  = trimSum - trimPeriod;
        next_r.trimLive = (r.trimLive > 16'sh0000) ? r.trimLive - 16'sh0001
                                                   : r.trimLive + 16'sh0001;
      end else begin
        next_r.trimAcc = trimSum;
      end
    end

    // Registered outputs
    next_r.atZero     = zeroNow;
    next_r.rampActive = (r.state == ST_RAMP || r.state == ST_FAST) &&
                        (next_r.speed != r.speed);
    next_r.drive      = (next_r.state != ST_IDLE);
    next_r.brake      = (next_r.state == ST_DCB);
    next_r.idle       = (next_r.state == ST_IDLE);
    next_r.tlim       = (next_r.state == ST_FAST) ? r.fastTlim : r.normTlim;
    if (next_r.state == ST_IDLE || next_r.state == ST_DCB) begin
      next_r.demand = 18'sh00000;
    end else begin
      next_r.demand = $signed({2'b00, next_r.speed}) + 18'(next_r.trimLive);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register update with synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '{mode: RST_MODE, decelTime: RST_DECEL_TIME, stopTime: RST_STOP_TIME,
             zeroPct: RST_ZERO_PCT, stopDelay: RST_STOP_DELAY, fastLimit: RST_FAST_LIMIT,
             fastTime: RST_FAST_TIME, trimRate: RST_TRIM_RATE, fastTlim: RST_FAST_TLIM,
             normTlim: RST_NORM_TLIM, state: ST_IDLE, idle: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state record
  assign wbDatR        = r.rdat;
  assign wbAck         = r.ack;
  assign speedDemand   = r.demand;
  assign driveEnable   = r.drive;
  assign dcBrake       = r.brake;
  assign torqueLimit   = r.tlim;
  assign quenched      = r.idle;
  assign rampingActive = r.rampActive;

endmodule : dss_drive_stop_sequencer

/* core/dss_pkg.sv */
// Package with constants, register map and state codes for the drive stop sequencer
package dss_pkg;

  // Clock and time base
  localparam int unsigned    CLK_PERIOD_NS = 4;
  localparam int unsigned    TENTH_S_NS    = 100_000_000;
  localparam int unsigned    CYC_PER_TENTH = TENTH_S_NS / CLK_PERIOD_NS;
  localparam longint unsigned CLK_HZ       = 64'd1_000_000_000 / CLK_PERIOD_NS;

  // Scaling of settings
  localparam int unsigned PCT_SCALE      = 1000;  // Threshold unit is 0.1 percent
  localparam int unsigned FLOOR_DHZ      = 5;     // Zero speed floor, 0.5 Hz in 0.1 Hz
  localparam int unsigned HZ_TO_DHZ      = 10;
  localparam int unsigned MAX_FREQ_DHZ   = 500;   // Frequency at full speed, 0.1 Hz units
  localparam logic [15:0] FULL_SPEED     = 16'h7FFF;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_DECEL_TIME = 8'h04;
  localparam logic [7:0] ADDR_STOP_TIME  = 8'h08;
  localparam logic [7:0] ADDR_ZERO_PCT   = 8'h0C;
  localparam logic [7:0] ADDR_STOP_DELAY = 8'h10;
  localparam logic [7:0] ADDR_FAST_LIMIT = 8'h14;
  localparam logic [7:0] ADDR_FAST_TIME  = 8'h18;
  localparam logic [7:0] ADDR_TRIM_RATE  = 8'h1C;
  localparam logic [7:0] ADDR_FAST_TLIM  = 8'h20;
  localparam logic [7:0] ADDR_NORM_TLIM  = 8'h24;
  localparam logic [7:0] ADDR_STATUS     = 8'h28;
  localparam logic [7:0] ADDR_DEMAND     = 8'h2C;

  // Status field positions
  localparam int unsigned STAT_RAMPING = 0;
  localparam int unsigned STAT_ZERO    = 1;
  localparam int unsigned STAT_STATE   = 8;

  // Reset values, times in 0.1 s
  localparam logic [1:0]  RST_MODE       = 2'h0;
  localparam logic [15:0] RST_DECEL_TIME = 16'h0064;
  localparam logic [15:0] RST_STOP_TIME  = 16'h0064;
  localparam logic [15:0] RST_ZERO_PCT   = 16'h0001;
  localparam logic [15:0] RST_STOP_DELAY = 16'h0005;
  localparam logic [15:0] RST_FAST_LIMIT = 16'h012C;
  localparam logic [15:0] RST_FAST_TIME  = 16'h0001;
  localparam logic [15:0] RST_TRIM_RATE  = 16'h04B0;
  localparam logic [15:0] RST_FAST_TLIM  = 16'h05DC;
  localparam logic [15:0] RST_NORM_TLIM  = 16'h05DC;

  // Stop modes
  typedef enum logic [1:0] {
    MODE_RAMP      = 2'h0,
    MODE_COAST     = 2'h1,
    MODE_DC_BRAKE  = 2'h2,
    MODE_STOP_RAMP = 2'h3
  } dss_mode_type;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RUN  = 6'h02,
    ST_RAMP = 6'h04,
    ST_FAST = 6'h08,
    ST_HOLD = 6'h10,
    ST_DCB  = 6'h20
  } dss_state_type;

endpackage : dss_pkg

/* test/dss_stop_checker_assertions.sv */
// Port checker for the drive stop sequencer
`timescale 1ns/1ps
module dss_stop_checker (
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic               wbCyc,
  input wire logic               wbStb,
  input wire logic               wbAck,
  input wire logic               runCmd,
  input wire logic               vectorMode,
  input wire logic signed [17:0] speedDemand,
  input wire logic               driveEnable,
  input wire logic               dcBrake,
  input wire logic               quenched,
  input wire logic               rampingActive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Run command withdrawn for two cycles
  sequence sRunGone;
    !runCmd [*2];
  endsequence
  // Quenched for two cycles
  sequence sIdle;
    quenched ##1 quenched;
  endsequence
  ////////////////////////////////////////
  AST_ACK_ONE:
    assert property (wbAck |=> !wbAck) else $error("ack held too long");
  AST_ACK_NEXT:
    assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("ack missing");
  AST_ACK_CAUSE:
    assert property (!(wbCyc && wbStb) |=> !wbAck) else $error("ack without request");
  AST_QUENCH_OFF:
    assert property (quenched |-> !driveEnable && speedDemand == 18'sh0)
      else $error("drive active while quenched");
  AST_BRAKE_ZERO:
    assert property (dcBrake |-> driveEnable && speedDemand == 18'sh0)
      else $error("brake with speed demand");
  AST_BRAKE_VECT:
    assert property (dcBrake |-> !vectorMode) else $error("brake under vector control");
  AST_FLAG_IDLE:
    assert property (sIdle |-> !rampingActive) else $error("ramping flag while idle");
  AST_STOP_FALL:
    assert property (sRunGone ##0 driveEnable |-> speedDemand <= $past(speedDemand))
      else $error("demand rose during stop");
endmodule : dss_stop_checker
bind dss_drive_stop_sequencer dss_stop_checker u_chk (.mclk(mclk), .rst(rst),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .runCmd(runCmd),
  .vectorMode(vectorMode), .speedDemand(speedDemand), .driveEnable(driveEnable),
  .dcBrake(dcBrake), .quenched(quenched), .rampingActive(rampingActive));

/* test/dss_motor_model.sv */
// Behavioural motor stage fed by the speed demand
`timescale 1ns/1ps
module dss_motor_model (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic signed [17:0] speedDemand,
  input  wire logic               driveEnable,
  input  wire logic               dcBrake,
  output logic signed [17:0]      motorSpeed
);
  // Shaft follows demand when driven, brakes hard, else freewheels slowly
  always_ff @(posedge mclk) begin
    if (rst) begin
      motorSpeed <= 18'sh0;
    end else if (dcBrake) begin
      motorSpeed <= motorSpeed >>> 1;
    end else if (driveEnable) begin
      motorSpeed <= speedDemand;
    end else if (motorSpeed > 18'sh0) begin
      motorSpeed <= motorSpeed - 18'sh1;
    end
  end
endmodule : dss_motor_model

/* test/dss_drive_stop_sequencer_tb_top.sv */
// Self-checking bench for the drive stop sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0d got %0d", n, e, g); end end
module dss_drive_stop_sequencer_tb_top;
  import dss_pkg::*;
  localparam int TEN = 10;
  logic mclk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck;
  logic [7:0] wbAdr = 0;
  logic [31:0] wbDatW = 0, wbDatR;
  logic runCmd = 0, fastStopN = 1, vectorMode = 0;
  logic [15:0] refSpeed = 0, torqueLimit;
  logic signed [15:0] trimIn = 0;
  logic signed [17:0] speedDemand, motorSpeed;
  logic driveEnable, dcBrake, quenched, rampingActive;
  int seed = 32'hd3886980, error_cnt = 0, checks_done = 0, cyc = 0;
  int cm[8] = '{0, 1, 2, 2, 3, 0, 0, 0};
  int cv[8] = '{0, 0, 0, 1, 0, 0, 0, 0};
  int cz[8] = '{1, 1, 1, 1, 1, 100, 1, 1};
  int cd[8] = '{20, 20, 20, 20, 20, 20, 0, 20};
  logic [31:0] rv[10] = '{0, 100, 100, 1, 5, 300, 1, 1200, 32'h5DC, 32'h5DC};
  ////////////////////////////////////////
  dss_drive_stop_sequencer #(.CYC_TENTH(TEN)) u_dut (.mclk(mclk), .rst(rst),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hF),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .runCmd(runCmd),
    .fastStopN(fastStopN), .vectorMode(vectorMode), .refSpeed(refSpeed),
    .trimIn(trimIn), .speedDemand(speedDemand), .driveEnable(driveEnable),
    .dcBrake(dcBrake), .torqueLimit(torqueLimit), .quenched(quenched),
    .rampingActive(rampingActive));
  dss_motor_model u_motor (.mclk(mclk), .rst(rst), .speedDemand(speedDemand),
    .driveEnable(driveEnable), .dcBrake(dcBrake), .motorSpeed(motorSpeed));
  ////////////////////////////////////////
  // Clock and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // One classic bus cycle, released after ack is sampled or after 8 extra cycles without ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    wbCyc <= 1;
    wbStb <= 1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    @(posedge mclk);
    while (wbAck !== 1'b1 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    `CHK("ack", 0, n / 8)
    q = wbDatR;
    wbCyc <= 0;
    wbStb <= 0;
    @(posedge mclk);
  endtask : wb
  // Zero speed threshold in demand units, floor wins when larger
  function automatic int thr(int z);
    int a = z * int'(FULL_SPEED) / int'(PCT_SCALE);
    int b = int'(FLOOR_DHZ) * int'(FULL_SPEED) / int'(MAX_FREQ_DHZ);
    return a > b ? a : b;
  endfunction : thr
  // Count that lies within tolerance reads as the expected one
  function automatic int fit(int e, int g, int d);
    return (g >= e - d && g <= e + d) ? e : g;
  endfunction : fit
  // One stop sequence of table entry k
  task automatic stop_case(input int k);
    int s, tr, n, nr, nb, lr, t;
    logic [31:0] q;
    logic [15:0] ftl;
    logic seen;
    s = 16'h1000 + ($random(seed) & 16'h2FFF);
    tr = $random(seed) & 15;
    ftl = 16'($random(seed));
    wb(1, ADDR_CTRL, cm[k], q);
    wb(1, ADDR_DECEL_TIME, cd[k], q);
    wb(1, ADDR_ZERO_PCT, cz[k], q);
    wb(1, ADDR_FAST_TLIM, {16'h0, ftl}, q);
    vectorMode <= cv[k][0];
    refSpeed <= 16'(s);
    trimIn <= 16'(tr);
    runCmd <= 1;
    repeat (6) @(posedge mclk);
    `CHK("demand", 18'(s + tr), speedDemand)
    `CHK("torque", 16'h05DC, torqueLimit)
    if (k == 7) fastStopN <= 0;
    else runCmd <= 0;
    n = 0; nr = 0; nb = 0; lr = 0; seen = 0;
    while (quenched !== 1'b1 && n < 600) begin
      @(posedge mclk);
      n++;
      if (rampingActive === 1'b1) begin nr++; lr = n; end
      if (dcBrake === 1'b1) nb++;
      if (torqueLimit === ftl) seen = 1;
    end
    t = cm[k] == 3 ? 40 : cd[k];
    if (k == 7) begin
      `CHK("fast end", 31, fit(31, n, 2))
      `CHK("fast tlim", 1'b1, seen)
      `CHK("fast ramp", 1, nr > 0)
    end else if (cm[k] == 1 || cv[k] == 1 || t == 0) begin
      `CHK("coast end", 2, fit(2, n, 1))
      `CHK("coast flag", 0, nr)
      `CHK("freewheel", 1, motorSpeed > 0)
    end else if (cm[k] == 2) begin
      `CHK("brake", 20, fit(20, nb, 1))
    end else begin
      `CHK("ramp", (s - thr(cz[k])) * t * TEN / 32767,
           fit((s - thr(cz[k])) * t * TEN / 32767, nr, 2))
      `CHK("hold", 21, fit(21, n - lr, 2))
    end
    runCmd <= 0;
    @(posedge mclk);
    fastStopN <= 1;
    repeat (4) @(posedge mclk);
  endtask : stop_case
  ////////////////////////////////////////
  // Reset, register defaults, then every stop mode and a timed-out fast stop
  initial begin
    logic [31:0] q;
    repeat (16) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      wb(0, 8'(i * 4), 0, q);
      `CHK("reset reg", rv[i], q)
    end
    wb(1, ADDR_STATUS, 32'hFFFF, q);
    wb(0, ADDR_STATUS, 0, q);
    `CHK("status", 32'h0100, q & 32'h3F01)
    wb(0, 8'h30, 0, q);
    `CHK("unmapped", 32'h0, q)
    wb(1, ADDR_STOP_TIME, 40, q);
    wb(1, ADDR_STOP_DELAY, 2, q);
    wb(1, ADDR_FAST_TIME, 600, q);
    wb(1, ADDR_FAST_LIMIT, 3, q);
    for (int k = 0; k < 8; k++) stop_case(k);
    tally_and_finish();
  end
endmodule : dss_drive_stop_sequencer_tb_top
